// [core/boundary_scan_tap.sv]
// boundary-scan test access port: controller, instruction, boundary,
// bypass and identification registers behind a four-wire serial port
// assumes clk is much faster than the test clock and the ring snapshot
// input is synchronous to clk

`timescale 1ns/1ps

module boundary_scan_tap #(
  parameter int          BSR_LEN = tap_pkg::BSR_LEN_DEF,
  parameter logic [31:0] ID_CODE = tap_pkg::ID_CODE_DEF   // arbitrary value
) (
  input  wire logic               clk,           // core sampling clock
  input  wire logic               reset_n,       // async power-up reset, active low
  input  wire logic               tck,           // test clock pin
  input  wire logic               tms,           // mode select pin level
  input  wire logic               tms_driven,    // mode select pin driven by board
  input  wire logic               tdi,           // serial data in pin level
  input  wire logic               tdi_driven,    // serial data in pin driven by board
  input  wire logic [BSR_LEN-1:0] ring_capture,  // snapshot of the I/O ring
  output logic                    tdo,           // serial data out
  output logic                    tdo_oe,        // serial data out enable, high drives
  output logic                    sram_out_hiz,  // force memory outputs to high Z
  output logic                    tap_in_reset   // controller sits in reset state
);

  // elaboration checks
  generate
    if (BSR_LEN < 2) begin : g_bad_len
      $error("boundary register needs at least two cells");
    end
    if (ID_CODE[0] != 1'b1) begin : g_bad_id
      $error("identification value must have bit 0 set");
    end
  endgenerate

  // ---- pin synchronisation ----
  wire tck_s;      // test clock level
  wire tms_s;      // mode select level
  wire tms_drv_s;  // mode select driven
  wire tdi_s;      // serial data level
  wire tdi_drv_s;  // serial data driven

  // test clock idles low; driven flags reset low so pulled pins read high
  tap_sync #(
    .WIDTH     (5),
    .RESET_VAL (8'h00)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({tck, tms, tms_driven, tdi, tdi_driven}),
    .sync_out ({tck_s, tms_s, tms_drv_s, tdi_s, tdi_drv_s})
  );

  // internal pull-ups: a floating pin reads high
  wire tms_eff = tms_drv_s ? tms_s : 1'b1;  // RULE3
  wire tdi_eff = tdi_drv_s ? tdi_s : 1'b1;  // RULE3

  // ---- test clock edge detection ----
  logic tck_prev_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tck_prev_q <= 1'b0;
    else          tck_prev_q <= tck_s;
  end

  // only these strobes advance the controller and shift stages; memory clock never does
  wire tck_rise = tck_s & ~tck_prev_q;  // RULE5
  wire tck_fall = ~tck_s & tck_prev_q;  // RULE5

  // ---- controller ----
  tap_pkg::tap_state_e state_q;
  tap_pkg::tap_state_e state_d;

  // step on the rise, steered by mode select
  assign state_d = tck_rise ? tap_pkg::tap_next(state_q, tms_eff) : state_q;  // RULE6 RULE8

  // power-up lands in the reset state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) state_q <= tap_pkg::ST_TLR;  // RULE4
    else          state_q <= state_d;          // RULE9
  end

  // state decodes
  wire st_tlr   = (state_q == tap_pkg::ST_TLR);
  wire st_cap_i = (state_q == tap_pkg::ST_CAPTURE_IR);
  wire st_shf_i = (state_q == tap_pkg::ST_SHIFT_IR);
  wire st_upd_i = (state_q == tap_pkg::ST_UPDATE_IR);
  wire st_cap_d = (state_q == tap_pkg::ST_CAPTURE_DR);
  wire st_shf_d = (state_q == tap_pkg::ST_SHIFT_DR);
  wire in_shift = st_shf_i | st_shf_d;

  // ---- instruction register ----
  logic [tap_pkg::IR_WIDTH-1:0] ir_sr_q;  // shift stage
  logic [tap_pkg::IR_WIDTH-1:0] ir_q;     // active instruction

  // capture pattern, then shift in at the top
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ir_sr_q <= tap_pkg::IR_CAPTURE_VAL;
    else if (tck_rise && st_cap_i) ir_sr_q <= tap_pkg::IR_CAPTURE_VAL;  // RULE16
    else if (tck_rise && st_shf_i) ir_sr_q <= {tdi_eff, ir_sr_q[tap_pkg::IR_WIDTH-1:1]};  // RULE11
  end

  // the reset state alone forces identify, no test clock rise needed, so a
  // mode-select reset drops an isolating instruction at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ir_q <= tap_pkg::INSTR_IDCODE;
    else if (st_tlr)               ir_q <= tap_pkg::INSTR_IDCODE;  // RULE16
    else if (tck_rise && st_upd_i) ir_q <= ir_sr_q;
  end

  // reserved codes fall back to bypass so the chain stays one bit long
  wire sel_bsr = (ir_q == tap_pkg::INSTR_EXTEST) | (ir_q == tap_pkg::INSTR_SAMPLE_Z)
               | (ir_q == tap_pkg::INSTR_SAMPLE);  // RULE10
  wire sel_id  = (ir_q == tap_pkg::INSTR_IDCODE);  // RULE10
  wire sel_byp = ~sel_bsr & ~sel_id;               // RULE10
  wire hiz_d   = (ir_q == tap_pkg::INSTR_EXTEST) | (ir_q == tap_pkg::INSTR_SAMPLE_Z);

  wire cap_dr = tck_rise & st_cap_d;
  wire shf_dr = tck_rise & st_shf_d;

  // ---- data registers ----
  logic [BSR_LEN-1:0]           bsr_q;
  logic [tap_pkg::ID_WIDTH-1:0] id_q;
  logic                         byp_q;

  // boundary cells: snapshot of the ring, no preload to the pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) bsr_q <= '0;
    else if (cap_dr && sel_bsr) bsr_q <= ring_capture;                    // RULE1
    else if (shf_dr && sel_bsr) bsr_q <= {tdi_eff, bsr_q[BSR_LEN-1:1]};  // RULE11
  end

  // hardwired code captured, then shifted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) id_q <= '0;
    else if (cap_dr && sel_id) id_q <= ID_CODE;                 // RULE18
    else if (shf_dr && sel_id) id_q <= {tdi_eff, id_q[tap_pkg::ID_WIDTH-1:1]};  // RULE18
  end

  // single bypass cell, cleared on capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) byp_q <= 1'b0;
    else if (cap_dr && sel_byp) byp_q <= tap_pkg::BYPASS_CAPTURE;  // RULE17
    else if (shf_dr && sel_byp) byp_q <= tdi_eff;                  // RULE11
  end

  // ---- serial output ----
  wire dr_lsb = sel_id ? id_q[0] : (sel_bsr ? bsr_q[0] : byp_q);  // RULE12
  wire tdo_d  = st_shf_i ? ir_sr_q[0] : dr_lsb;                     // RULE12

  logic tdo_q;
  logic tdo_oe_q;

  // data and enable change only on the fall, so the far end samples a
  // stable bit at its next rise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q    <= in_shift ? tdo_d : 1'b0;  // RULE7
      tdo_oe_q <= in_shift;                 // RULE13 RULE14
    end
  end

  // ---- side outputs ----
  logic hiz_q;
  logic in_reset_q;

  // identify after reset leaves the memory outputs alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hiz_q      <= 1'b0;
      in_reset_q <= 1'b1;
    end else begin
      hiz_q      <= hiz_d;   // RULE4
      in_reset_q <= st_tlr;  // RULE15
    end
  end

  assign tdo          = tdo_q;
  assign tdo_oe       = tdo_oe_q;
  assign sram_out_hiz = hiz_q;
  assign tap_in_reset = in_reset_q;

  // ---- checks ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // count of consecutive high mode-select rises, saturating
  logic [2:0] tms_hi_cnt_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tms_hi_cnt_q <= 3'h0;
    else if (tck_rise && !tms_eff) tms_hi_cnt_q <= 3'h0;
    else if (tck_rise && tms_hi_cnt_q < 3'(tap_pkg::TLR_TMS_EDGES)) begin
      tms_hi_cnt_q <= tms_hi_cnt_q + 3'h1;
    end
  end

  AST_FIVE_HIGH_RESETS: // RULE15
    assert property (tms_hi_cnt_q == 3'(tap_pkg::TLR_TMS_EDGES) |-> st_tlr)
      else $error("five high mode-select edges did not reach reset state");

  AST_STATE_MOVES_ON_RISE: // RULE6
    assert property (!$past(tck_rise) |-> $stable(state_q))
      else $error("controller moved without a test clock rise");

  AST_TDO_MOVES_ON_FALL: // RULE7
    assert property (!$past(tck_fall) |-> $stable(tdo_q) && $stable(tdo_oe_q))
      else $error("serial output changed without a test clock fall");

  AST_OE_ONLY_SHIFT: // RULE14
    assert property (tck_fall |=> tdo_oe_q == $past(in_shift))
      else $error("output enable does not follow shift state");

  AST_IR_CAPTURE_PATTERN: // RULE16
    assert property (tck_rise && st_cap_i |=> ir_sr_q[1:0] == 2'h1)
      else $error("instruction capture pattern wrong");

  AST_RESET_LOADS_ID: // RULE16
    assert property (st_tlr |=> ir_q == tap_pkg::INSTR_IDCODE ##1 sel_id)
      else $error("reset state did not load identify instruction");

  AST_BYPASS_CLEARED: // RULE17
    assert property (cap_dr && sel_byp |=> !byp_q)
      else $error("bypass cell not cleared on capture");

  AST_ID_CAPTURED: // RULE18
    assert property (cap_dr && sel_id |=> id_q == ID_CODE)
      else $error("identification value not captured");

  AST_SHIFT_INTO_MSB: // RULE11
    assert property (shf_dr && sel_bsr |=> bsr_q[BSR_LEN-1] == $past(tdi_eff))
      else $error("serial input not placed in register top bit");

  AST_LSB_ON_TDO: // RULE12
    assert property (tck_fall && st_shf_d && sel_id |=> tdo_q == $past(id_q[0]) && tdo_oe_q)
      else $error("serial output is not the register bottom bit");

  AST_PULLUP_HIGH: // RULE3
    assert property (!tms_drv_s && !tdi_drv_s |-> tms_eff && tdi_eff)
      else $error("undriven pin not read as high");

  AST_ID_NO_HIZ: // RULE4
    assert property (sel_id ##1 sel_id |-> !hiz_q)
      else $error("memory outputs disturbed under identify");

  // register paths, output enable, memory isolation and controller steps
  AST_BYPASS_SHIFT: // RULE11
    assert property (shf_dr && sel_byp |=> byp_q == $past(tdi_eff))
      else $error("serial input not placed in bypass cell");

  AST_QUIET_OUTSIDE_SHIFT: // RULE14
    assert property (tck_fall && !in_shift |=> !tdo_oe_q && !tdo_q)
      else $error("serial output driven outside shift states");

  AST_IR_SHIFT_MSB: // RULE11
    assert property (tck_rise && st_shf_i |=> ir_sr_q[tap_pkg::IR_WIDTH-1] == $past(tdi_eff))
      else $error("serial input not placed in instruction top bit");

  AST_IR_LSB_ON_TDO: // RULE12
    assert property (tck_fall && st_shf_i |=> tdo_q == $past(ir_sr_q[0]) && tdo_oe_q)
      else $error("serial output is not the instruction bottom bit");

  AST_RING_CAPTURED: // RULE1
    assert property (cap_dr && sel_bsr |=> bsr_q == $past(ring_capture))
      else $error("ring snapshot not captured");

  AST_ID_SHIFT_MSB: // RULE11
    assert property (shf_dr && sel_id |=> id_q[tap_pkg::ID_WIDTH-1] == $past(tdi_eff))
      else $error("serial input not placed in identification top bit");

  AST_IR_UPDATE_COMMITS: // RULE10
    assert property (tck_rise && st_upd_i |=> ir_q == $past(ir_sr_q))
      else $error("update did not commit the shifted instruction");

  AST_HIZ_ONLY_ISOLATING: // RULE4
    assert property (hiz_q |-> $past(ir_q) == tap_pkg::INSTR_EXTEST
                     || $past(ir_q) == tap_pkg::INSTR_SAMPLE_Z)
      else $error("memory outputs isolated without an isolating instruction");

  AST_RESET_STATE_HOLDS: // RULE8
    assert property (st_tlr && tck_rise && tms_eff |=> st_tlr)
      else $error("reset state left with mode select high");

  AST_RESET_STATE_LEAVES: // RULE8
    assert property (st_tlr && tck_rise && !tms_eff |=> state_q == tap_pkg::ST_RTI)
      else $error("reset state did not step to idle");

  AST_SEL_IR_TO_RESET: // RULE8
    assert property (tck_rise && state_q == tap_pkg::ST_SEL_IR && tms_eff |=> st_tlr)
      else $error("instruction select did not step to reset");

  AST_BYPASS_ON_TDO: // RULE12
    assert property (tck_fall && st_shf_d && sel_byp |=> tdo_q == $past(byp_q))
      else $error("serial output is not the bypass cell");

  AST_BSR_ON_TDO: // RULE12
    assert property (tck_fall && st_shf_d && sel_bsr |=> tdo_q == $past(bsr_q[0]))
      else $error("serial output is not the boundary bottom bit");

  AST_OE_WHEN_SHIFTING: // RULE13
    assert property (tck_fall && in_shift |=> tdo_oe_q)
      else $error("output enable low in a shift state");

endmodule // boundary_scan_tap

// [core/tap_pkg.sv]
// constants, state encoding and next-state decode for the boundary-scan port
// assumes the test clock is sampled by a much faster core clock
//
// Operation
// RULE1: controller, instruction, boundary, bypass, identification registers present
// RULE2: controller parks test clock low when unused
// RULE3: undriven data and mode-select inputs read high
// RULE4: power-up enters reset state, memory undisturbed
// RULE5: test clock drives only test logic
// RULE6: inputs taken on test clock rising edge
// RULE7: outputs change on test clock falling edge
// RULE8: sixteen-state diagram steered by mode select
// RULE9: mode select is the controller command input
// RULE10: instruction chooses the data register in path
// RULE11: serial input enters selected register's MSB
// RULE12: serial output shows selected register's LSB
// RULE13: output enable follows controller state
// RULE14: output driven only in shift states
// RULE15: five high mode-select edges reset logic
// RULE16: three-bit instruction, identify on reset, capture 01
// RULE17: one-bit bypass register cleared on capture
// RULE18: 32-bit hardwired code captured then shifted out

package tap_pkg;

  localparam int IR_WIDTH      = 3;
  localparam int ID_WIDTH      = 32;
  localparam int TLR_TMS_EDGES = 5;   // consecutive high mode-select edges to reset
  localparam int BSR_LEN_DEF   = 65;  // boundary cells, plain default
  localparam int SYNC_STAGES   = 2;

  // instruction codes
  localparam logic [2:0] INSTR_EXTEST   = 3'h0;
  localparam logic [2:0] INSTR_IDCODE   = 3'h1;
  localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INSTR_SAMPLE   = 3'h4;
  localparam logic [2:0] INSTR_BYPASS   = 3'h7;

  // capture pattern of the instruction shift stage
  localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
  localparam logic       BYPASS_CAPTURE = 1'h0;

  // identification value, arbitrary, bit 0 set as usual
  localparam logic [31:0] ID_CODE_DEF = 32'h0000_0001;

  typedef enum logic [3:0] {
    ST_TLR        = 4'h0,
    ST_RTI        = 4'h1,
    ST_SEL_DR     = 4'h2,
    ST_CAPTURE_DR = 4'h3,
    ST_SHIFT_DR   = 4'h4,
    ST_EXIT1_DR   = 4'h5,
    ST_PAUSE_DR   = 4'h6,
    ST_EXIT2_DR   = 4'h7,
    ST_UPDATE_DR  = 4'h8,
    ST_SEL_IR     = 4'h9,
    ST_CAPTURE_IR = 4'hA,
    ST_SHIFT_IR   = 4'hB,
    ST_EXIT1_IR   = 4'hC,
    ST_PAUSE_IR   = 4'hD,
    ST_EXIT2_IR   = 4'hE,
    ST_UPDATE_IR  = 4'hF
  } tap_state_e;

  // standard controller diagram, one step per test clock rise
  function automatic tap_state_e tap_next(input tap_state_e s, input logic tms);
    tap_state_e n;
    n = ST_TLR;
    case (s)
      ST_TLR:        n = tms ? ST_TLR       : ST_RTI;
      ST_RTI:        n = tms ? ST_SEL_DR    : ST_RTI;
      ST_SEL_DR:     n = tms ? ST_SEL_IR    : ST_CAPTURE_DR;
      ST_CAPTURE_DR: n = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_SHIFT_DR:   n = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_EXIT1_DR:   n = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   n = tms ? ST_EXIT2_DR  : ST_PAUSE_DR;
      ST_EXIT2_DR:   n = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  n = tms ? ST_SEL_DR    : ST_RTI;
      ST_SEL_IR:     n = tms ? ST_TLR       : ST_CAPTURE_IR;
      ST_CAPTURE_IR: n = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_SHIFT_IR:   n = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_EXIT1_IR:   n = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   n = tms ? ST_EXIT2_IR  : ST_PAUSE_IR;
      ST_EXIT2_IR:   n = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  n = tms ? ST_SEL_DR    : ST_RTI;
      default:       n = ST_TLR;
    endcase
    return n;
  endfunction

endpackage

// [core/tap_sync.sv]
// two-stage synchroniser for a group of pin levels
// assumes the inputs are quasi-static against clk between test clock edges

`timescale 1ns/1ps

module tap_sync #(
  parameter int           WIDTH     = 1,
  parameter logic [7:0]   RESET_VAL = 8'h00
) (
  input  wire logic             clk,       // core clock
  input  wire logic             reset_n,   // async reset, active low
  input  wire logic [WIDTH-1:0] async_in,  // pin levels
  output logic      [WIDTH-1:0] sync_out   // synchronised levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  generate
    if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
      $error("tap_sync width must be 1 to 8");
    end
  endgenerate

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RESET_VAL[WIDTH-1:0];
      sync_q <= RESET_VAL[WIDTH-1:0];
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // tap_sync

// [verification/tap_host_model.sv]
// model of the board-level scan controller that drives the test port
// assumes the bench sequences the controller states through these tasks
`timescale 1ns/1ps
module tap_host_model (
  output logic      tck,         // test clock, parked low
  output logic      tms,         // mode select level
  output logic      tms_driven,  // mode select driven
  output logic      tdi,         // serial data level
  output logic      tdi_driven,  // serial data driven
  input  wire logic tdo,         // serial data out
  input  wire logic tdo_oe       // serial data out enable
);
  localparam realtime HALF = 62.5;
  // idle: clock parked low so the port never advances
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tms_driven = 1'b1;
    tdi = 1'b0;
    tdi_driven = 1'b0;
  end
  // one period: levels change after a fall, tdo is taken just before the rise
  task automatic step(input logic m, input logic d, output logic o, output logic oe);
    tms = m;
    tms_driven = 1'b1;
    tdi = d;
    tdi_driven = 1'b1;
    #HALF;
    o = tdo;
    oe = tdo_oe;
    tck = 1'b1;
    #HALF;
    tck = 1'b0;
  endtask
  // released line shows the inverse level; only the pull-up gives a defined value
  task automatic release_tdi();
    tdi_driven = 1'b0;
    tdi = ~tdi;
  endtask
  // mode select left floating while the clock runs: the pull-up steers it high
  task automatic float_tms(input int rises);
    tms_driven = 1'b0;
    tms = 1'b0;
    repeat (rises) begin
      #HALF;
      tck = 1'b1;
      #HALF;
      tck = 1'b0;
    end
  endtask
endmodule  // tap_host_model

// [verification/tb_top.sv]
// self-checking bench for the boundary-scan port
// assumes the host model drives the pins and the bench walks the states
`timescale 1ns/1ps
module tb_top;
  localparam int          BSR  = 8;
  localparam logic [7:0]  RING = 8'hA5;
  localparam logic [31:0] ID   = 32'h1357_9BDF;  // arbitrary value
  logic           clk, reset_n, tck, tms, tms_driven, tdi, tdi_driven;
  logic [BSR-1:0] ring_capture;
  logic           tdo, tdo_oe, sram_out_hiz, tap_in_reset;
  logic           o, oe, oe_all;
  logic [63:0]    dout;
  int             miscompares = 0;
  int             tests_run = 0;

  boundary_scan_tap #(.BSR_LEN(BSR), .ID_CODE(ID)) u_dut (
    .clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tms_driven(tms_driven),
    .tdi(tdi), .tdi_driven(tdi_driven), .ring_capture(ring_capture), .tdo(tdo),
    .tdo_oe(tdo_oe), .sram_out_hiz(sram_out_hiz), .tap_in_reset(tap_in_reset));
  tap_host_model u_host (
    .tck(tck), .tms(tms), .tms_driven(tms_driven), .tdi(tdi),
    .tdi_driven(tdi_driven), .tdo(tdo), .tdo_oe(tdo_oe));

  // core clock, unrelated in phase to the test clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // steer mode select, bits taken lsb first
  task automatic walk(input logic [3:0] path, input int n);
    for (int i = 0; i < n; i++) begin
      u_host.step(path[i], 1'b0, o, oe);
    end
  endtask

  // n bits from a shift state, then update and back to idle
  task automatic scan(input logic [63:0] din, input int n);
    dout = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      u_host.step(i == n - 1, din[i], o, oe);
      dout[i] = o;
      oe_all &= oe;
    end
    walk(4'b0001, 2);
    u_host.release_tdi();
    #60;
  endtask

  task automatic load_ir(input logic [2:0] code);
    walk(4'b0011, 4);
    scan({61'h0, code}, 3);
  endtask

  task automatic t_reset();
    chk("in_reset", 64'h1, tap_in_reset);
    chk("oe_idle", 64'h0, tdo_oe);
    chk("hiz_idle", 64'h0, sram_out_hiz);
    walk(4'b0000, 1);
    #60;
    chk("left_reset", 64'h0, tap_in_reset);
  endtask

  // 33 bits: code leaves lsb first, then the first tdi bit reappears
  task automatic t_idcode();
    walk(4'b0001, 3);
    scan(64'h0000_0001_C3A5_96F1, 33);
    chk("idcode", {32'h0, ID}, {32'h0, dout[31:0]});
    chk("tdi_msb", 64'h1, dout[32]);
    chk("oe_shift", 64'h1, oe_all);
    chk("oe_after", 64'h0, tdo_oe);
    chk("tdo_after", 64'h0, tdo);
  endtask

  task automatic t_ir_bypass();
    walk(4'b0011, 4);
    scan(64'h7, 3);
    chk("ir_capture", 64'h1, dout);
    walk(4'b0001, 3);
    scan(64'hB, 4);
    chk("bypass", 64'h6, dout);
  endtask

  // each boundary instruction picks the boundary register; reserved code behaves as bypass
  task automatic t_codes();
    logic [2:0] code [4] = '{3'h0, 3'h2, 3'h4, 3'h3};
    logic       hz   [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic       byp  [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    for (int k = 0; k < 4; k++) begin
      load_ir(code[k]);
      chk("hiz", {63'h0, hz[k]}, sram_out_hiz);
      walk(4'b0001, 3);
      scan(64'h3C, BSR);
      chk("dr_path", byp[k] ? 64'h78 : {56'h0, RING}, dout);
    end
  endtask

  // floating mode select: four rises stop short of reset, the fifth enters it
  task automatic t_tms_reset();
    load_ir(3'h2);
    walk(4'b0001, 3);
    u_host.float_tms(4);
    #60;
    chk("not_yet", 64'h0, tap_in_reset);
    u_host.float_tms(1);
    #60;
    chk("tms_reset", 64'h1, tap_in_reset);
    chk("ir_reload", 64'h0, sram_out_hiz);
  endtask

  // power-up reset in mid-run drops an isolating instruction
  task automatic t_power_up();
    walk(4'b0000, 1);
    load_ir(3'h0);
    chk("hiz_set", 64'h1, sram_out_hiz);
    @(posedge clk);
    #1;
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("pwr_reset", 64'h1, tap_in_reset);
    chk("pwr_hiz", 64'h0, sram_out_hiz);
    chk("pwr_oe", 64'h0, tdo_oe);
  endtask

  task automatic end_sim();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence after a three-cycle reset
  initial begin
    reset_n = 1'b0;
    ring_capture = '0;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    ring_capture = RING;
    repeat (5) @(posedge clk);
    #1;
    t_reset();
    t_idcode();
    t_ir_bypass();
    t_codes();
    t_tms_reset();
    t_power_up();
    end_sim();
  end

  // watchdog well beyond the roughly 20 us the scans need
  initial begin
    #200000;
    miscompares++;
    $display("mismatch watchdog expected done seen hang");
    end_sim();
  end
endmodule  // tb_top
